// >>> design/lcc_top.sv
// Light conversion control: APB registers, conversion timing, ranging and flags
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lcc_top #(
    parameter int CONV_SHORT_CYC = lcc_pkg::CONV_SHORT_MS * lcc_pkg::CYC_PER_MS,
    parameter int CONV_LONG_CYC  = lcc_pkg::CONV_LONG_MS * lcc_pkg::CYC_PER_MS
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [lcc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [lcc_pkg::LIGHT_W-1:0] light_level,
    input  wire logic                        overload_pin,
    output logic                             irq
);
    if (CONV_SHORT_CYC < 2 || CONV_LONG_CYC < 2 || CONV_LONG_CYC >= (1 << lcc_pkg::TIMER_W)) begin : g_bad_cyc
        $error("lcc_top: conversion cycle counts out of range");
    end

    localparam logic [lcc_pkg::TIMER_W-1:0] SHORT_LOAD = lcc_pkg::TIMER_W'(CONV_SHORT_CYC - 1);
    localparam logic [lcc_pkg::TIMER_W-1:0] LONG_LOAD  = lcc_pkg::TIMER_W'(CONV_LONG_CYC - 1);

    lcc_pkg::lcc_cfg_s           cfg;
    logic [15:0]                 result;
    logic [15:0]                 high_limit;
    logic [lcc_pkg::IRQ_W-1:0]   irq_status;
    logic [lcc_pkg::IRQ_W-1:0]   irq_mask;
    logic                        running;
    logic [lcc_pkg::TIMER_W-1:0] timer;
    logic [lcc_pkg::TIMER_W-1:0] elapsed;
    logic [3:0]                  cur_range;
    logic                        transient_seen;
    logic [3:0]                  fault_cnt;
    logic [lcc_pkg::LIGHT_W-1:0] light_meta;
    logic [lcc_pkg::LIGHT_W-1:0] light_sync;
    logic                        ovl_meta;
    logic                        ovl_sync;

    // Analog code is quasi-static over a conversion, so a plain two-stage sync is enough
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            light_meta <= '0;
            light_sync <= '0;
            ovl_meta   <= 1'b0;
            ovl_sync   <= 1'b0;
        end else begin
            light_meta <= light_level;
            light_sync <= light_meta;
            ovl_meta   <= overload_pin;
            ovl_sync   <= ovl_meta;
        end
    end

    // Bus decode
    logic [3:0] idx;
    logic       mapped;
    logic       access;
    logic       cfg_wr;
    logic       cfg_rd;
    assign idx    = paddr[lcc_pkg::IDX_LSB +: 4];
    assign mapped = (paddr[lcc_pkg::IDX_LSB-1:0] == 2'b00) && (paddr[lcc_pkg::ADDR_W-1:lcc_pkg::IDX_LSB+4] == '0) &&
                    (idx == lcc_pkg::IDX_RESULT || idx == lcc_pkg::IDX_CONFIG || idx == lcc_pkg::IDX_HIGH_LIMIT ||
                     idx == lcc_pkg::IDX_IRQ_STATUS || idx == lcc_pkg::IDX_IRQ_MASK);
    assign access = psel && penable && pready && mapped;
    assign cfg_wr = access && pwrite && idx == lcc_pkg::IDX_CONFIG;
    assign cfg_rd = access && !pwrite && idx == lcc_pkg::IDX_CONFIG;

    lcc_pkg::lcc_cfg_s wcfg;
    assign wcfg = lcc_pkg::lcc_cfg_s'(pwdata[15:0]);

    // Measurement at the active range
    logic [lcc_pkg::LIGHT_W-1:0] scaled;
    logic                        ovf_now;
    logic                        auto_mode;
    logic                        done;
    logic                        step_up;
    assign auto_mode = cfg.range_select_field == lcc_pkg::RANGE_AUTO;
    assign scaled    = light_sync >> cur_range;
    assign ovf_now   = |scaled[lcc_pkg::LIGHT_W-1:lcc_pkg::MANT_W];
    assign step_up   = running && !cfg_wr && auto_mode && ovf_now && cur_range < lcc_pkg::RANGE_MAX;
    assign done      = running && !cfg_wr && !step_up && timer == '0;

    // Resolution loss on short integration, low ranges only
    logic [lcc_pkg::MANT_W-1:0] mant;
    logic [lcc_pkg::MANT_W-1:0] drop_mask;
    always_comb begin
        drop_mask = '1;
        if (!cfg.integration_time_select) begin
            if (cur_range == lcc_pkg::RANGE_ONE_BIT)
                drop_mask = 12'hffe;
            else if (cur_range == lcc_pkg::RANGE_THREE_BIT)
                drop_mask = 12'hff8;
            else if (cur_range < lcc_pkg::RANGE_ONE_BIT)
                drop_mask = 12'hffc;
        end
        // Saturate at full scale, same LSB weight for both times
        mant = (ovf_now ? '1 : scaled[lcc_pkg::MANT_W-1:0]) & drop_mask;
    end

    logic ovf_final;
    assign ovf_final = ovf_now || (!auto_mode && transient_seen);

    // Comparison against high limit in linear units
    logic [lcc_pkg::LIN_W-1:0] res_lin;
    logic [lcc_pkg::LIN_W-1:0] lim_lin;
    logic                      above;
    logic [3:0]                need;
    logic [3:0]                next_fault_cnt;
    assign res_lin = lcc_pkg::LIN_W'({mant, 15'h0000} >> (15 - cur_range));
    assign lim_lin = lcc_pkg::LIN_W'({high_limit[11:0], 15'h0000} >> (15 - high_limit[15:12]));
    assign above   = res_lin > lim_lin;
    assign need    = 4'h1 << cfg.fault_count_field;
    assign next_fault_cnt = (fault_cnt == 4'hf) ? fault_cnt : fault_cnt + 4'h1;

    // Conversion sequencing
    logic [lcc_pkg::TIMER_W-1:0] load;
    logic [lcc_pkg::TIMER_W-1:0] wload;
    assign load  = cfg.integration_time_select ? LONG_LOAD : SHORT_LOAD;
    assign wload = wcfg.integration_time_select ? LONG_LOAD : SHORT_LOAD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running        <= 1'b0;
            timer          <= '0;
            elapsed        <= '0;
            cur_range      <= '0;
            transient_seen <= 1'b0;
        end else if (cfg_wr) begin
            // Abort on any config write; restart unless the new mode is shutdown
            running        <= wcfg.mode != lcc_pkg::LCC_MODE_SHUT;
            timer          <= wload;
            elapsed        <= '0;
            cur_range      <= (wcfg.range_select_field == lcc_pkg::RANGE_AUTO) ? '0 :
                              (wcfg.range_select_field > lcc_pkg::RANGE_AUTO ? cur_range : wcfg.range_select_field);
            transient_seen <= 1'b0;
        end else if (step_up) begin
            timer          <= load;
            elapsed        <= '0;
            cur_range      <= cur_range + 4'h1;
            transient_seen <= 1'b0;
        end else if (done) begin
            running        <= cfg.mode[1];
            timer          <= load;
            elapsed        <= '0;
            cur_range      <= auto_mode ? '0 : cur_range;
            transient_seen <= 1'b0;
        end else if (running) begin
            timer          <= timer - 1'b1;
            elapsed        <= elapsed + 1'b1;
            transient_seen <= transient_seen || ovl_sync;
        end
    end

    // Configuration register and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= lcc_pkg::CONFIG_RESET;
        end else begin
            if (cfg_wr) begin
                // Reserved range codes are refused, old range kept
                if (wcfg.range_select_field <= lcc_pkg::RANGE_AUTO)
                    cfg.range_select_field <= wcfg.range_select_field;
                cfg.integration_time_select <= wcfg.integration_time_select;
                cfg.mode                    <= wcfg.mode;
                cfg.latch                   <= wcfg.latch;
                cfg.polarity                <= wcfg.polarity;
                cfg.mask_exp                <= wcfg.mask_exp;
                cfg.fault_count_field       <= wcfg.fault_count_field;
                if (wcfg.mode != lcc_pkg::LCC_MODE_SHUT)
                    cfg.conversion_ready_flag <= 1'b0;
            end else if (done) begin
                cfg.conversion_ready_flag <= 1'b1;
                cfg.overflow_flag         <= ovf_final;
                if (cfg.mode == lcc_pkg::LCC_MODE_SINGLE)
                    cfg.mode <= lcc_pkg::LCC_MODE_SHUT;
                if (above && next_fault_cnt >= need)
                    cfg.high_limit_flag <= 1'b1;
                else if (!above && !cfg.latch)
                    cfg.high_limit_flag <= 1'b0;
                else if (cfg_rd && prdata[lcc_pkg::CFG_FH_BIT] && cfg.latch)
                    cfg.high_limit_flag <= 1'b0;
            end else if (cfg_rd) begin
                // Clear only what the read actually returned
                if (prdata[lcc_pkg::CFG_CRF_BIT])
                    cfg.conversion_ready_flag <= 1'b0;
                if (prdata[lcc_pkg::CFG_FH_BIT] && cfg.latch)
                    cfg.high_limit_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_cnt <= '0;
            result    <= '0;
        end else if (done) begin
            fault_cnt <= above ? next_fault_cnt : '0;
            result    <= {cur_range, mant};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            high_limit <= lcc_pkg::HIGH_LIMIT_RESET;
        else if (access && pwrite && idx == lcc_pkg::IDX_HIGH_LIMIT)
            high_limit <= pwdata[15:0];
    end

    // Interrupt status, write one to clear; a new event beats the clear
    logic [lcc_pkg::IRQ_W-1:0] ev;
    logic [lcc_pkg::IRQ_W-1:0] w1c;
    logic [lcc_pkg::IRQ_W-1:0] next_irq_status;
    always_comb begin
        ev = '0;
        ev[lcc_pkg::IRQ_DONE_BIT] = done;
        ev[lcc_pkg::IRQ_HIGH_BIT] = done && above && next_fault_cnt >= need && !cfg.high_limit_flag;
        ev[lcc_pkg::IRQ_OVF_BIT]  = done && ovf_final;
        w1c = (access && pwrite && idx == lcc_pkg::IDX_IRQ_STATUS) ? pwdata[lcc_pkg::IRQ_W-1:0] : '0;
        next_irq_status = (irq_status & ~w1c) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            irq_mask   <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (access && pwrite && idx == lcc_pkg::IDX_IRQ_MASK)
                irq_mask <= pwdata[lcc_pkg::IRQ_W-1:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // APB: data captured in setup, answer in first access cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (idx)
            lcc_pkg::IDX_RESULT:     rd_mux[15:0] = result;
            lcc_pkg::IDX_CONFIG:     rd_mux[15:0] = cfg;
            lcc_pkg::IDX_HIGH_LIMIT: rd_mux[15:0] = high_limit;
            lcc_pkg::IDX_IRQ_STATUS: rd_mux[lcc_pkg::IRQ_W-1:0] = irq_status;
            lcc_pkg::IDX_IRQ_MASK:   rd_mux[lcc_pkg::IRQ_W-1:0] = irq_mask;
            default:                 rd_mux = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable)
                prdata <= (mapped && !pwrite) ? rd_mux : '0;
        end
    end

    // Checks
    AST_MODE_SHUT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.mode == lcc_pkg::LCC_MODE_SHUT |-> !running)
        else $error("converting while in shutdown");
    AST_SINGLE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        done && cfg.mode == lcc_pkg::LCC_MODE_SINGLE |=> cfg.mode == lcc_pkg::LCC_MODE_SHUT && !running)
        else $error("single shot did not return to shutdown");
    AST_CONV_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> elapsed == load)
        else $error("conversion length wrong");
    AST_CRF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        done |=> cfg.conversion_ready_flag)
        else $error("ready flag not set at conversion end");
    AST_CRF_READ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_rd && prdata[lcc_pkg::CFG_CRF_BIT] && !done |=> !cfg.conversion_ready_flag)
        else $error("ready flag survived a read");
    AST_SHUT_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr && wcfg.mode == lcc_pkg::LCC_MODE_SHUT |=> $stable(cfg.conversion_ready_flag) && $stable(cfg.high_limit_flag))
        else $error("shutdown write changed a flag");
    AST_AUTO_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        step_up |=> cur_range == $past(cur_range) + 4'h1 && elapsed == '0)
        else $error("auto range did not step up");
    AST_NO_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.range_select_field <= lcc_pkg::RANGE_AUTO)
        else $error("reserved range code stored");
    AST_FH_AT_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg.high_limit_flag) |-> $past(done) && $past(above))
        else $error("high flag rose outside a completed result");
    AST_FAULT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        done && !above |=> fault_cnt == '0)
        else $error("fault counter not cleared");
    AST_OVF_FINAL: assert property (@(posedge pclk) disable iff (!presetn)
        done && auto_mode && !ovf_now |=> !cfg.overflow_flag)
        else $error("overflow set in auto range without overload");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == $past(|(irq_status & irq_mask)))
        else $error("interrupt output disagrees with status");

    COV_SINGLE: cover property (@(posedge pclk) disable iff (!presetn) done && cfg.mode == lcc_pkg::LCC_MODE_SINGLE);
    COV_STEP:   cover property (@(posedge pclk) disable iff (!presetn) step_up);
    COV_HIGH:   cover property (@(posedge pclk) disable iff (!presetn) $rose(cfg.high_limit_flag));
    COV_ABORT:  cover property (@(posedge pclk) disable iff (!presetn) running && cfg_wr);
endmodule
`default_nettype wire

// >>> design/lcc_pkg.sv
// Constants and types of the light conversion control block
package lcc_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [3:0] IDX_RESULT     = 4'h0;
    localparam logic [3:0] IDX_CONFIG     = 4'h1;
    localparam logic [3:0] IDX_HIGH_LIMIT = 4'h3;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK   = 4'h5;
    localparam int         ADDR_W         = 8;
    localparam int         IDX_LSB        = 2;

    localparam logic [15:0] CONFIG_RESET     = 16'hc810;
    localparam logic [15:0] HIGH_LIMIT_RESET = 16'hbfff;
    localparam logic [3:0]  RANGE_AUTO       = 4'hc;
    localparam logic [3:0]  RANGE_MAX        = 4'hb;
    localparam logic [3:0]  RANGE_ONE_BIT    = 4'h5;
    localparam logic [3:0]  RANGE_THREE_BIT  = 4'h0;
    localparam int          MANT_W           = 12;
    localparam int          LIGHT_W          = 23;
    localparam int          LIN_W            = 28;

    // Configuration field positions
    localparam int CFG_RANGE_LSB = 12;
    localparam int CFG_CT_BIT    = 11;
    localparam int CFG_MODE_LSB  = 9;
    localparam int CFG_OVF_BIT   = 8;
    localparam int CFG_CRF_BIT   = 7;
    localparam int CFG_FH_BIT    = 6;
    localparam int CFG_LATCH_BIT = 4;

    // Interrupt status bits
    localparam int IRQ_W        = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_HIGH_BIT = 1;
    localparam int IRQ_OVF_BIT  = 2;

    // Conversion timing
    localparam int CLK_HZ        = 20000000;
    localparam int CONV_SHORT_MS = 100;
    localparam int CONV_LONG_MS  = 800;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int TIMER_W       = 24;

    typedef enum logic [1:0] {
        LCC_MODE_SHUT   = 2'b00,
        LCC_MODE_SINGLE = 2'b01,
        LCC_MODE_CONT   = 2'b10,
        LCC_MODE_CONT2  = 2'b11
    } lcc_mode_e;

    typedef struct packed {
        logic [3:0] range_select_field;
        logic       integration_time_select;
        lcc_mode_e  mode;
        logic       overflow_flag;
        logic       conversion_ready_flag;
        logic       high_limit_flag;
        logic       low_flag;
        logic       latch;
        logic       polarity;
        logic       mask_exp;
        logic [1:0] fault_count_field;
    } lcc_cfg_s;
endpackage

// >>> sim/lcc_apb_host.sv
// APB host model that performs register transfers for the bench
`timescale 1ns/1ps
`default_nettype none
module lcc_apb_host (
    input  wire logic                       pclk,
    output logic                            psel,
    output logic                            penable,
    output logic                            pwrite,
    output logic [lcc_pkg::ADDR_W-1:0]      paddr,
    output logic [31:0]                     pwdata,
    input  wire logic [31:0]                prdata,
    input  wire logic                       pready,
    input  wire logic                       pslverr
);
    logic timed_out;
    initial begin
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = '0;
        pwdata    = '0;
        timed_out = 1'b0;
    end
    // Request held until pready seen at a rising edge; no wait count assumed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer looked at mid-cycle where it is settled; it stands until the next rising edge
        @(negedge pclk);
        while (pready !== 1'b1 && n < 32) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 32) timed_out = 1'b1;
        q = prdata;
        e = pslverr;
        // Released only after the rising edge that samples pready high
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sim/test_light_conversion_control.sv
// Self-checking bench of the light conversion control block
`timescale 1ns/1ps
`default_nettype none
module test_light_conversion_control;
    localparam int SHORT_CYC = 20;
    localparam int LONG_CYC  = 40;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [22:0] light_level = '0;
    logic        overload_pin = 1'b0;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          n, v;
    logic [3:0]  rn [4] = '{4'h0, 4'h5, 4'h6, 4'h0};
    logic        tm [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    int          ol [4] = '{32'h2000, 32'h100, 32'h100, 32'h7fffff};
    logic        op [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    always #25 pclk = ~pclk;
    lcc_apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lcc_top #(.CONV_SHORT_CYC(SHORT_CYC), .CONV_LONG_CYC(LONG_CYC)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .light_level(light_level), .overload_pin(overload_pin), .irq(irq));
    // Config word; flags are read-only so zero on writes, latch kept at 1
    function automatic logic [31:0] cfg(logic [3:0] r, logic t, logic [1:0] m, logic [2:0] f, logic [1:0] c);
        return {16'h0, r, t, m, f, 1'b0, 1'b1, 2'b00, c};
    endfunction
    // Reference result: auto ranging, saturation, short-time resolution loss
    function automatic logic [15:0] model(int lt, int r0, logic t, output logic o);
        int r, m;
        r = r0;
        if (r0 == 12) begin
            r = 0;
            while (r < 11 && (lt >> r) > 4095) r++;
        end
        m = lt >> r;
        o = (m > 4095);
        if (o) m = 4095;
        if (!t && r == 5) m = m & ~1;
        else if (!t && r >= 1 && r <= 4) m = m & ~3;
        else if (!t && r == 0) m = m & ~7;
        return {r[3:0], m[11:0]};
    endfunction
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp || host_u.timed_out) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rd, err);
        if (host_u.timed_out) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        host_u.xfer(1'b0, a, 32'h0, rd, err);
        cmp(what, exp, rd);
        if (host_u.timed_out) end_of_test();
    endtask
    // Clear all status bits, then let the interrupt level fall before anyone waits on it
    task automatic clr_irq();
        wr(8'h10, 32'h7);
        repeat (2) @(negedge pclk);
    endtask
    // Bounded wait for the interrupt level; n counts falling edges, where irq is settled
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 400) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic set_light(input int lt, input logic o);
        @(posedge pclk);
        light_level  <= lt[22:0];
        overload_pin <= o;
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        logic [15:0] res;
        logic        ov;
        void'($urandom(32'h98be6414));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h04, 32'h0000c810, "config reset");
        rdc(8'h0c, 32'h0000bfff, "high limit reset");
        rdc(8'h10, 32'h0, "irq status reset");
        rdc(8'h08, 32'h0, "unmapped read");
        cmp("unmapped error", 32'h1, {31'h0, err});
        wr(8'h14, 32'h7);
        rdc(8'h14, 32'h7, "irq mask");
        $display("Test reset and map done");
        for (int i = 0; i < 4; i++) begin
            v = ($urandom & 32'hfff) << rn[i];
            set_light(v, 1'b0);
            res = model(v, rn[i], tm[i], ov);
            wr(8'h04, cfg(rn[i], tm[i], 2'b01, 3'b000, 2'b00));
            rdc(8'h04, cfg(rn[i], tm[i], 2'b01, 3'b000, 2'b00), "single mode busy");
            wait_irq();
            v = tm[i] ? LONG_CYC : SHORT_CYC;
            cmp("conversion time ok", 32'h1, {31'h0, n >= v - 8 && n <= v + 3});
            rdc(8'h04, cfg(rn[i], tm[i], 2'b00, 3'b010, 2'b00), "single done config");
            rdc(8'h00, {16'h0, res}, "result");
            rdc(8'h04, cfg(rn[i], tm[i], 2'b00, 3'b000, 2'b00), "ready read clear");
            rdc(8'h10, 32'h1, "irq status done");
            clr_irq();
            cmp("irq cleared", 32'h0, {31'h0, irq});
        end
        $display("Test single-shot done");
        set_light(32'h12345, 1'b0);
        res = model(32'h12345, 12, 1'b1, ov);
        wr(8'h04, cfg(4'hc, 1'b1, 2'b10, 3'b000, 2'b00));
        wait_irq();
        rdc(8'h00, {16'h0, res}, "auto range result");
        clr_irq();
        wait_irq();
        wr(8'h04, cfg(4'hd, 1'b1, 2'b00, 3'b000, 2'b00));
        cmp("irq kept in shutdown", 32'h1, {31'h0, irq});
        rdc(8'h04, cfg(4'hc, 1'b1, 2'b00, 3'b010, 2'b00), "shutdown keeps ready");
        wr(8'h10, 32'h7);
        $display("Test auto range and shutdown done");
        for (int i = 0; i < 4; i++) begin
            set_light(ol[i], op[i]);
            res = model(ol[i], i == 3 ? 12 : 0, 1'b1, ov);
            ov = ov | op[i];
            wr(8'h04, cfg(i == 3 ? 4'hc : 4'h0, 1'b1, 2'b01, 3'b000, 2'b00));
            wait_irq();
            rdc(8'h00, {16'h0, res}, "overflow result");
            rdc(8'h04, cfg(i == 3 ? 4'hc : 4'h0, 1'b1, 2'b00, {ov, 2'b10}, 2'b00), "overflow flag");
            rdc(8'h10, {29'h0, ov, 2'b01}, "irq status overflow");
            wr(8'h10, 32'h7);
        end
        $display("Test overflow done");
        set_light(32'h800, 1'b0);
        wr(8'h0c, 32'h0001);
        wr(8'h04, cfg(4'h0, 1'b1, 2'b11, 3'b000, 2'b01));
        wait_irq();
        rdc(8'h04, cfg(4'h0, 1'b1, 2'b11, 3'b010, 2'b01), "high flag after one");
        clr_irq();
        wait_irq();
        rdc(8'h10, 32'h3, "irq status high");
        wr(8'h04, cfg(4'h0, 1'b1, 2'b11, 3'b000, 2'b01));
        rdc(8'h04, cfg(4'h0, 1'b1, 2'b11, 3'b001, 2'b01), "write clears ready");
        wr(8'h04, cfg(4'h0, 1'b1, 2'b00, 3'b000, 2'b01));
        $display("Test high flag done");
        end_of_test();
    end
endmodule
`default_nettype wire
